// >>> awt_assertions.sv
// concurrent checks on the watchdog top-level ports
`include "awt_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module awt_assertions #(
   parameter int CNT_W = 32
) (
   // clock and resets
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  pulse_logic_reset_n_i,
   // bus and timeout output
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [`AWT_ADR_W-1:0] wb_adr_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire logic                  timeout_reset_out_o
);
   logic armed_q;
   wire logic rd_ack = wb_ack_o && !wb_we_i;
   wire logic rl_ack = wb_ack_o && wb_we_i && (wb_adr_i == `AWT_OFF_LOAD || wb_adr_i == `AWT_OFF_REFRESH);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // set by reset or a reload write, spent by a timeout pulse
   always_ff @(posedge clk_i) begin
      armed_q <= rst_i || rl_ack || (armed_q && !$rose(timeout_reset_out_o));
   end
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack without strobe");
   pulse_four_a: assert property ($rose(timeout_reset_out_o) |-> timeout_reset_out_o[*4] ##1 !timeout_reset_out_o)
      else $error("timeout pulse not four cycles");
   rearm_only_a: assert property ($rose(timeout_reset_out_o) |-> armed_q)
      else $error("second pulse without reload");
   refresh_zero_a: assert property (rd_ack && wb_adr_i == `AWT_OFF_REFRESH |-> wb_dat_o == 32'h0)
      else $error("refresh address read not zero");
   ctrl_high_a: assert property (rd_ack && wb_adr_i == `AWT_OFF_CTRL |-> wb_dat_o[31:5] == 27'h0)
      else $error("control upper bits not zero");
   pulse_clear_a: assert property (!pulse_logic_reset_n_i [*4] |-> !timeout_reset_out_o)
      else $error("pulse output high in its reset");
   cover property ($rose(timeout_reset_out_o));
   cover property (rd_ack && wb_adr_i == `AWT_OFF_REFRESH);
   cover property (rl_ack);
   cover property (!pulse_logic_reset_n_i [*4]);
endmodule // awt_assertions
bind awt_top awt_assertions #(.CNT_W(CNT_W)) i_chk (.clk_i, .rst_i, .pulse_logic_reset_n_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .timeout_reset_out_o);
`default_nettype wire

// >>> awt_defs.svh
// register map, field positions, reset values and timing counts of the watchdog
// How it works
// (RULE1) counter width is a build-time parameter, 16 or 32 bits, never changed at run time
// (RULE2) counter width defaults to 32 bits; 16 bits is the only alternative
// (RULE3) counter loads from the stored load value and counts down only while enabled
// (RULE4) enabled counter reaching zero asserts the system timeout reset output
// (RULE5) timeout reset output is active high for exactly four clock cycles per timeout
// (RULE6) any write to the refresh address reloads the counter; written data is ignored
// (RULE7) writing the load register restarts the count from the new value at once
// (RULE8) counter decrements only on single-cycle prescaler enable pulses, no derived clock
// (RULE9) prescaler runs on the bus clock, pulsing every 2 to 1024 periods
// (RULE10) software must refresh often enough that the counter never reaches zero
// (RULE11) a bus reset input initialises the bus-side logic and registers
// (RULE12) the pulse circuitry is cleared only by its own active-low reset input
// (RULE13) that pulse-logic reset is asserted on hardware reset only, never by the timeout
// (RULE14) control bit 4 is enable, reset 0; bits 3:0 select the prescale
// (RULE15) prescale code 0 divides by 2, doubling to code 9 for 1024; higher codes 1024
// (RULE16) refresh address reads zero; current count readable from a read-only register
// (RULE17) at zero the counter holds and pulses no more until reloaded
// (RULE18) while disabled the counter holds and the prescaler issues no pulses
`ifndef AWT_DEFS_SVH
`define AWT_DEFS_SVH

`define AWT_ADR_W          8
`define AWT_OFF_LOAD       8'h00
`define AWT_OFF_VALUE      8'h04
`define AWT_OFF_CTRL       8'h08
`define AWT_OFF_REFRESH    8'h0C

`define AWT_CTRL_EN_BIT    4
`define AWT_CTRL_PS_MSB    3
`define AWT_CTRL_PS_LSB    0

`define AWT_LOAD_RST       32'h0000_0000
`define AWT_VALUE_RST      32'hFFFF_FFFF
`define AWT_CTRL_EN_RST    1'h0
`define AWT_CTRL_PS_RST    4'h0

`define AWT_CNT_W_DEFAULT  32
`define AWT_PS_MAX_CODE    4'h9
`define AWT_PS_CNT_W       10
`define AWT_PULSE_CYCLES   3'h4

`endif

// >>> awt_pkg.sv
// types shared by the watchdog top level and its prescaler and pulse generator
package awt_pkg;

   // bus-side state of the top level
   typedef struct packed {
      logic [31:0] load;
      logic [31:0] count;
      logic        enable;
      logic [3:0]  prescale;
      logic        ack;
      logic [31:0] rdata;
      logic        fire;
   } awt_regs_s;

   // prescaler state
   typedef struct packed {
      logic [9:0] div_cnt;
      logic       tick;
   } awt_pre_s;

   // timeout pulse state
   typedef struct packed {
      logic       sync_a;
      logic       sync_b;
      logic [2:0] remain;
      logic       pulse;
   } awt_pls_s;

   // control fields as seen by the prescaler
   typedef struct packed {
      logic       enable;
      logic [3:0] prescale;
   } awt_ctrl_s;

endpackage

// >>> awt_prescaler.sv
// prescaler: one-cycle count enable every 2..1024 clock periods
`include "awt_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module awt_prescaler (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // control
   input  wire awt_pkg::awt_ctrl_s ctrl_i,
   input  wire logic              restart_i,
   // enable pulse
   output logic                   tick_o
);
   import awt_pkg::*;

   awt_pre_s                 s_q;
   awt_pre_s                 s_d;
   logic [3:0]               code;
   logic [`AWT_PS_CNT_W-1:0] last;

   always_comb begin
      s_d  = s_q;
      code = (ctrl_i.prescale > `AWT_PS_MAX_CODE) ? `AWT_PS_MAX_CODE : ctrl_i.prescale; // [RULE15]
      last = {{(`AWT_PS_CNT_W-1){1'b0}}, 1'b1};
      last = (last << (code + 4'h1)) - 10'h001;
      s_d.tick = 1'b0;
      if (!ctrl_i.enable || restart_i) begin
         s_d.div_cnt = '0;                                 // [RULE18]
      end else if (s_q.div_cnt >= last) begin
         s_d.div_cnt = '0;
         s_d.tick    = 1'b1;                               // [RULE9]
      end else begin
         s_d.div_cnt = s_q.div_cnt + 10'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
endmodule // awt_prescaler
`default_nettype wire

// >>> awt_pulse_gen.sv
// timeout pulse generator with its own active-low reset
`include "awt_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module awt_pulse_gen (
   // clock and dedicated reset pin
   input  wire logic clk_i,
   input  wire logic pulse_logic_reset_n_i,
   // trigger and output
   input  wire logic fire_i,
   output logic      timeout_reset_out_o
);
   import awt_pkg::*;

   awt_pls_s s_q;
   awt_pls_s s_d;

   // the reset pin is synchronised; only the second stage is read
   always_comb begin
      s_d        = s_q;
      s_d.sync_a = pulse_logic_reset_n_i;
      s_d.sync_b = s_q.sync_a;
      if (!s_q.sync_b) begin
         s_d.remain = '0;                                   // [RULE12]
         s_d.pulse  = 1'b0;
      end else if (s_q.remain != 3'h0) begin
         s_d.remain = s_q.remain - 3'h1;
         s_d.pulse  = 1'b1;                                 // [RULE5]
      end else if (fire_i) begin
         s_d.remain = `AWT_PULSE_CYCLES - 3'h1;
         s_d.pulse  = 1'b1;                                 // [RULE4]
      end else begin
         s_d.pulse  = 1'b0;
      end
   end

   // no bus reset here: a timeout cannot cut its own pulse short
   always_ff @(posedge clk_i) begin
      s_q <= s_d;                                           // [RULE13]
   end

   assign timeout_reset_out_o = s_q.pulse;
endmodule // awt_pulse_gen
`default_nettype wire

// >>> awt_top.sv
// watchdog top level: wishbone register slave, down-counter and timeout output
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`include "awt_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module awt_top #(
   parameter int CNT_W = `AWT_CNT_W_DEFAULT                   // 16 or 32
) (
   // clock and bus reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   // dedicated reset of the pulse circuitry
   input  wire logic                  pulse_logic_reset_n_i,
   // wishbone classic slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [`AWT_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o,
   // system reset request
   output logic                       timeout_reset_out_o
);
   import awt_pkg::*;

   localparam logic [31:0] CNT_MASK = (CNT_W == 16) ? 32'h0000_FFFF : 32'hFFFF_FFFF; // [RULE1] [RULE2]

   localparam awt_regs_s REGS_RST = '{
      load:     `AWT_LOAD_RST,
      count:    `AWT_VALUE_RST & CNT_MASK,
      enable:   `AWT_CTRL_EN_RST,
      prescale: `AWT_CTRL_PS_RST,
      ack:      1'b0,
      rdata:    32'h0000_0000,
      fire:     1'b0
   };

   awt_regs_s   s_q;
   awt_regs_s   s_d;
   awt_ctrl_s   ctrl;
   logic        req;
   logic        commit;
   logic        wr;
   logic        sel_load;
   logic        sel_value;
   logic        sel_ctrl;
   logic        sel_refresh;
   logic        load_wr;
   logic        refresh_wr;
   logic        ctrl_wr;
   logic        tick;
   logic        restart;
   logic [31:0] lane_mask;
   logic [31:0] new_load;
   logic [31:0] ctrl_word;
   logic [31:0] new_ctrl;
   logic [31:0] read_word;

   // any build width other than 16 gives the 32-bit counter
   // byte lanes from the select lines
   generate
      for (genvar b = 0; b < 4; b++) begin : g_lane
         assign lane_mask[8*b +: 8] = {8{wb_sel_i[b]}};
      end
   endgenerate

   // address decode
   always_comb begin
      sel_load    = 1'b0;
      sel_value   = 1'b0;
      sel_ctrl    = 1'b0;
      sel_refresh = 1'b0;
      unique case (wb_adr_i)
         `AWT_OFF_LOAD:    sel_load    = 1'b1;
         `AWT_OFF_VALUE:   sel_value   = 1'b1;
         `AWT_OFF_CTRL:    sel_ctrl    = 1'b1;
         `AWT_OFF_REFRESH: sel_refresh = 1'b1;
         default: begin
            sel_load    = 1'b0;
         end
      endcase
   end

   // first cycle of a request raises ack; the write lands on the ack edge
   assign req        = wb_cyc_i & wb_stb_i;
   assign commit     = req & s_q.ack;
   assign wr         = commit & wb_we_i;
   assign load_wr    = wr & sel_load;
   assign refresh_wr = wr & sel_refresh;                    // [RULE6]
   assign ctrl_wr    = wr & sel_ctrl;

   // write data merged with the current contents under the byte lanes
   assign new_load  = ((s_q.load & ~lane_mask) | (wb_dat_i & lane_mask)) & CNT_MASK;
   assign ctrl_word = {27'h0, s_q.enable, s_q.prescale};
   assign new_ctrl  = (ctrl_word & ~lane_mask) | (wb_dat_i & lane_mask);

   // read multiplexer; unmapped and refresh addresses read zero
   always_comb begin
      read_word = 32'h0000_0000;
      if (sel_load) begin
         read_word = s_q.load & CNT_MASK;
      end else if (sel_value) begin
         read_word = s_q.count & CNT_MASK;                  // [RULE16]
      end else if (sel_ctrl) begin
         read_word = ctrl_word;
      end else if (sel_refresh) begin
         read_word = 32'h0000_0000;                         // [RULE16]
      end
   end

   // every reload restarts the prescale interval
   assign restart = load_wr | refresh_wr;

   always_comb begin
      s_d      = s_q;
      s_d.fire = 1'b0;

      // bus handshake
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack && !wb_we_i) begin
         s_d.rdata = read_word;
      end

      // register writes
      if (load_wr) begin
         s_d.load = new_load;
      end
      if (ctrl_wr) begin
         s_d.enable   = new_ctrl[`AWT_CTRL_EN_BIT];                      // [RULE14]
         s_d.prescale = new_ctrl[`AWT_CTRL_PS_MSB:`AWT_CTRL_PS_LSB];     // [RULE14]
      end

      // down-counter
      if (load_wr) begin
         s_d.count = new_load;                              // [RULE7]
      end else if (refresh_wr) begin
         s_d.count = s_q.load & CNT_MASK;                   // [RULE3] [RULE6]
      end else if (s_q.enable && tick && s_q.count != 32'h0000_0000) begin
         s_d.count = (s_q.count - 32'h0000_0001) & CNT_MASK; // [RULE3] [RULE8]
         s_d.fire  = (s_q.count == 32'h0000_0001);          // [RULE4]
      end else begin
         s_d.count = s_q.count;                             // [RULE17] [RULE18]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= REGS_RST;                                   // [RULE11]
      end else begin
         s_q <= s_d;
      end
   end

   // control fields to the prescaler
   assign ctrl.enable   = s_q.enable;
   assign ctrl.prescale = s_q.prescale;

   awt_prescaler u_prescaler (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ctrl_i    (ctrl),
      .restart_i (restart),
      .tick_o    (tick)
   );

   awt_pulse_gen u_pulse_gen (
      .clk_i                 (clk_i),
      .pulse_logic_reset_n_i (pulse_logic_reset_n_i),
      .fire_i                (s_q.fire),
      .timeout_reset_out_o   (timeout_reset_out_o)
   );

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdata;
endmodule // awt_top
`default_nettype wire

// >>> awt_wb_master.sv
// wishbone classic master model with one transfer task
`timescale 1ns/1ps
`default_nettype none
module awt_wb_master (
   // clock
   input  wire logic        clk_i,
   // request
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   // answer
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // request held until ack is sampled high; released data lines show the inverse
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      r = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d;
   endtask
endmodule // awt_wb_master
`default_nettype wire

// >>> test_awt_top.sv
// self-checking bench of the watchdog top level
`include "awt_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_awt_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        pls_n = 1'b0;
   logic        cyc, stb, we, ack, tout;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, r;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          hi, div;
   always #4 clk_i = ~clk_i;
   awt_wb_master i_mst (.clk_i, .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
   awt_top #(.CNT_W(32)) i_dut (.clk_i, .rst_i, .pulse_logic_reset_n_i(pls_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .timeout_reset_out_o(tout));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_mst.xfer(1'b1, a, 4'hF, d, r);
   endtask
   // write with only some byte lanes selected
   task automatic wrs(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      i_mst.xfer(1'b1, a, s, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      i_mst.xfer(1'b0, a, 4'hF, 32'h0, r);
      chk(r, e);
   endtask
   // cycles with the timeout output high over a window
   task automatic highs(input int n);
      hi = 0;
      repeat (n) begin
         @(posedge clk_i);
         hi += (tout === 1'b1);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      pls_n <= 1'b1; // pulse logic cleared at power-up, and held in its reset again in the last test
      rd(`AWT_OFF_LOAD, 32'h0);
      rd(`AWT_OFF_VALUE, 32'hFFFF_FFFF);
      rd(`AWT_OFF_CTRL, 32'h0);
      rd(8'h10, 32'h0);
      wr(`AWT_OFF_LOAD, 32'h1122_3344);
      wrs(`AWT_OFF_LOAD, 4'h2, 32'hAAAA_AAAA);
      rd(`AWT_OFF_LOAD, 32'h1122_AA44);
      wr(`AWT_OFF_CTRL, 32'hFFFF_FFFF);
      rd(`AWT_OFF_CTRL, 32'h1F);
      wr(`AWT_OFF_CTRL, 32'h0);
      wr(`AWT_OFF_LOAD, 32'h64);
      wr(`AWT_OFF_VALUE, 32'h1234);
      repeat (20) @(posedge clk_i);
      rd(`AWT_OFF_VALUE, 32'h64);
      // three ticks and a half period per code, codes above 9 as 1024
      for (int c = 0; c < 16; c++) begin
         div = (c < 10) ? (2 << c) : 1024;
         wr(`AWT_OFF_CTRL, 32'h0);
         wr(`AWT_OFF_LOAD, 32'h3E8);
         wr(`AWT_OFF_CTRL, 32'h10 | c);
         repeat (div * 3 + div / 2 - 3) @(posedge clk_i);
         wr(`AWT_OFF_CTRL, 32'h0);
         rd(`AWT_OFF_VALUE, 32'h3E5);
      end
      wr(`AWT_OFF_LOAD, 32'h3);
      wr(`AWT_OFF_CTRL, 32'h10);
      highs(40);
      chk(32'(hi), 32'h4);
      highs(40);
      chk(32'(hi), 32'h0);
      rd(`AWT_OFF_VALUE, 32'h0);
      wr(`AWT_OFF_LOAD, 32'h14);
      repeat (6) begin
         highs(12);
         chk(32'(hi), 32'h0);
         wr(`AWT_OFF_REFRESH, 32'hA5A5_A5A5);
      end
      wr(`AWT_OFF_CTRL, 32'h0);
      wr(`AWT_OFF_REFRESH, 32'h0);
      rd(`AWT_OFF_VALUE, 32'h14);
      rd(`AWT_OFF_REFRESH, 32'h0);
      wr(`AWT_OFF_CTRL, 32'h19);
      repeat (100) @(posedge clk_i);
      wr(`AWT_OFF_LOAD, 32'h1F4);
      wr(`AWT_OFF_CTRL, 32'h9);
      rd(`AWT_OFF_VALUE, 32'h1F4);
      rd(`AWT_OFF_LOAD, 32'h1F4);
      // bus reset during a running pulse: the pulse still runs its four cycles
      wr(`AWT_OFF_LOAD, 32'h3);
      wr(`AWT_OFF_CTRL, 32'h10);
      while (tout !== 1'b1) @(posedge clk_i);
      rst_i <= 1'b1;
      highs(8);
      chk(32'(hi), 32'h3); // one high cycle already seen
      rst_i <= 1'b0;
      rd(`AWT_OFF_VALUE, 32'hFFFF_FFFF);
      rd(`AWT_OFF_CTRL, 32'h0);
      // pulse logic held in its own reset: a timeout gives no pulse
      wr(`AWT_OFF_LOAD, 32'h3);
      pls_n <= 1'b0;
      wr(`AWT_OFF_CTRL, 32'h10);
      highs(20);
      chk(32'(hi), 32'h0);
      pls_n <= 1'b1;
      highs(8);
      chk(32'(hi), 32'h0);
      rd(`AWT_OFF_VALUE, 32'h0);
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge clk_i);
      n_mismatch++;
      print_verdict();
   end
endmodule // test_awt_top
`default_nettype wire
